// ---- test/reset_pin_partner.sv ----
/*
 Model of the outside reset circuitry on the shared active-low reset pin.
 Assumes a pull-up on the pin and the device's drive and enable outputs.
*/
`timescale 1ns/1ns
module reset_pin_partner (
   input wire logic hold_req,
   input wire logic dev_oe,
   input wire logic dev_out,
   output logic pin_level
);
   // Device drive wins, else outside hold, else pull-up
   assign pin_level = dev_oe ? dev_out : (hold_req ? 1'b0 : 1'b1);
endmodule : reset_pin_partner

// ---- test/tb_system_reset_source_controller.sv ----
/*
 Self-checking bench of the reset source controller over APB.
 Assumes the design's registered APB answer and the pin partner model.
*/
`timescale 1ns/1ns
`include "rst_src_params.svh"
module tb_system_reset_source_controller;
   logic clk_sys = 0, rst_b = 0, supply_low = 0, pin_hold = 0, clk_mon = 0, mon_run = 1;
   logic cmp_pos_below = 0, code_acc = 0, pin_rst_out, pin_rst_oe, core_rst, pin_level;
   logic [15:0] code_addr = 16'h0000;
   rst_src_pkg::apb_req_t req = '0;
   rst_src_pkg::apb_rsp_t rsp;
   logic [32:0] exp_q[$];
   integer fail_count = 0, checks_done = 0, seed = 32'h717bb520;
   integer hi_n = 0, last_len = 0, oe_hits = 0, n = 0;
   rst_src_ctrl i_rst_src_ctrl (.clk_sys(clk_sys), .rst_b(rst_b), .apb_req(req),
      .apb_rsp(rsp), .supply_low(supply_low), .pin_rst_in_b(pin_level),
      .pin_rst_out(pin_rst_out), .pin_rst_oe(pin_rst_oe), .clk_mon(clk_mon),
      .cmp_pos_below(cmp_pos_below), .code_acc(code_acc), .code_addr(code_addr),
      .core_rst(core_rst));
   reset_pin_partner i_reset_pin_partner (.hold_req(pin_hold), .dev_oe(pin_rst_oe),
      .dev_out(pin_rst_out), .pin_level(pin_level));
   ////////////////////////////////////////////////////////////////////////////////
   initial forever #50 clk_sys = ~clk_sys;
   always @(posedge clk_sys) if (mon_run) clk_mon <= ~clk_mon;
   always @(posedge clk_sys) begin
      if (core_rst === 1'b1 && pin_rst_oe === 1'b1) oe_hits = oe_hits + 1;
      if (core_rst === 1'b1) hi_n = hi_n + 1;
      else if (hi_n != 0) begin
         last_len = hi_n;
         hi_n = 0;
      end
   end
   // Read answer watcher
   always @(posedge clk_sys) if (req.psel && req.penable && !req.pwrite && rsp.pready === 1'b1) begin
      if (exp_q.size() == 0) chk("stray read", 33'h0, 33'h1);
      else chk("prdata", {rsp.pslverr, rsp.prdata}, exp_q.pop_front());
   end
   ////////////////////////////////////////////////////////////////////////////////
   task chk(input string nm, input logic [32:0] seen, input logic [32:0] exp);
      checks_done = checks_done + 1;
      if (seen !== exp) begin
         fail_count = fail_count + 1;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task give_verdict;
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : give_verdict
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      integer k;
      @(posedge clk_sys);
      req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
      @(posedge clk_sys);
      req.penable <= 1'b1;
      k = 0;
      do begin
         @(posedge clk_sys);
         k = k + 1;
      end while (rsp.pready !== 1'b1 && k < 50);
      req.psel <= 1'b0;
      req.penable <= 1'b0;
      if (k >= 50) begin
         chk("pready wait", 33'h0, 33'h1);
         give_verdict;
      end
   endtask : apb
   task rd(input logic [7:0] a, input logic [32:0] e);
      exp_q.push_back(e);
      apb(1'b0, a, 32'h0);
   endtask : rd
   // Wait for reset entry, then count cycles to release
   task settle(input integer lim);
      n = 0;
      while (core_rst !== 1'b1 && n < lim) begin
         @(posedge clk_sys);
         n = n + 1;
      end
      if (core_rst !== 1'b1) chk("reset entry", 33'h0, 33'h1);
      n = 0;
      while (core_rst !== 1'b0 && n < 2000) begin
         @(posedge clk_sys);
         n = n + 1;
      end
      if (n >= 2000 || core_rst !== 1'b0) begin
         chk("reset wait", 33'h0, 33'h1);
         give_verdict;
      end
   endtask : settle
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (5) @(posedge clk_sys);
      rst_b <= 1'b1;
      settle(5);
      rd(`CAUSE_OFS, 33'h02);
      rd(`WDT_LIM_OFS, {17'h0, `WDT_LIM_RST});
      rd(8'h0c, 33'h1_0000_0000);
      apb(1'b1, `CAUSE_OFS, 32'h12);
      settle(4);
      @(posedge clk_sys);
      chk("soft hold", 33'(last_len), 33'd4);
      rd(`CAUSE_OFS, 33'h10);
      rd(`WDT_CTL_OFS, 33'h1);
      code_addr <= 16'($random(seed)) & 16'h0fff;
      code_acc <= 1'b1;
      @(posedge clk_sys);
      code_addr <= 16'h1000 + (16'($random(seed)) & 16'h3fff);
      @(posedge clk_sys);
      code_acc <= 1'b0;
      settle(5);
      rd(`CAUSE_OFS, 33'h40);
      apb(1'b1, `CAUSE_OFS, 32'h22);
      cmp_pos_below <= 1'b1;
      settle(5);
      cmp_pos_below <= 1'b0;
      rd(`CAUSE_OFS, 33'h20);
      pin_hold <= 1'b1;
      repeat (10) @(posedge clk_sys);
      pin_hold <= 1'b0;
      settle(2);
      rd(`CAUSE_OFS, 33'h01);
      apb(1'b1, `CAUSE_OFS, 32'h06);
      mon_run <= 1'b0;
      settle(1100);
      mon_run <= 1'b1;
      rd(`CAUSE_OFS, 33'h04);
      chk("pin drive", 33'(oe_hits), 33'h0);
      supply_low <= 1'b1;
      repeat (10) @(posedge clk_sys);
      chk("supply pin", {32'h0, pin_rst_oe}, 33'h1);
      supply_low <= 1'b0;
      settle(2);
      chk("no por delay", {32'h0, n < 20}, 33'h1);
      rd(`CAUSE_OFS, 33'h02);
      apb(1'b1, `WDT_LIM_OFS, 32'h2);
      settle(100);
      rd(`CAUSE_OFS, 33'h20);
      give_verdict;
   end
endmodule : tb_system_reset_source_controller

// ---- verilog/rst_src_ctrl.sv ----
/*
 Reset source controller: merges supply, pin, clock loss, comparator,
 watchdog, code memory and software resets into one core reset and
 records the cause. Assumes synchronous inputs and an APB master.
*/
// Chosen here: the register addresses and the APB slave port.
`timescale 1ns/1ns
`include "rst_src_params.svh"

module rst_src_ctrl (
   input wire logic clk_sys,
   input wire logic rst_b,
   input rst_src_pkg::apb_req_t apb_req,
   output rst_src_pkg::apb_rsp_t apb_rsp,
   input wire logic supply_low,
   input wire logic pin_rst_in_b,
   output logic pin_rst_out,
   output logic pin_rst_oe,
   input wire logic clk_mon,
   input wire logic cmp_pos_below,
   input wire logic code_acc,
   input wire logic [15:0] code_addr,
   output logic core_rst
);
   rst_src_pkg::state_t r_r, r_nxt;
   logic [6:0] src;
   logic run, setup, wr, wr_cause, wr_ctl, wr_lim, wdt_exp;

   function automatic logic [6:0] first_src(input logic [6:0] s);
      first_src = '0;
      if (s[`B_SUP]) first_src[`B_SUP] = 1'b1;
      else if (s[`B_PIN]) first_src[`B_PIN] = 1'b1;
      else if (s[`B_MCD]) first_src[`B_MCD] = 1'b1;
      else if (s[`B_CMP]) first_src[`B_CMP] = 1'b1;
      else if (s[`B_MEM]) first_src[`B_MEM] = 1'b1;
      else if (s[`B_SW]) first_src[`B_SW] = 1'b1;
   endfunction : first_src

   ////////////////////////////////////////////////////////////////////////////
   // Bus decode and reset requests
   assign run = (r_r.ph == rst_src_pkg::PH_RUN);
   assign setup = apb_req.psel & ~apb_req.penable;
   assign wr = apb_req.psel & apb_req.penable & r_r.rsp.pready & apb_req.pwrite & run;
   assign wr_cause = wr & (apb_req.paddr == `CAUSE_OFS);
   assign wr_ctl = wr & (apb_req.paddr == `WDT_CTL_OFS);
   assign wr_lim = wr & (apb_req.paddr == `WDT_LIM_OFS);
   assign wdt_exp = r_r.wdt_en & (r_r.wdt_cnt >= r_r.wdt_lim);
   assign src[`B_SUP] = r_r.vdd_en & supply_low;
   assign src[`B_PIN] = ~pin_rst_in_b;
   assign src[`B_MCD] = r_r.mcd_en & (r_r.mcd_cnt >= 16'(`MCD_CYC));
   assign src[3] = 1'b0;
   assign src[`B_SW] = wr_cause & apb_req.pwdata[`B_SW];
   assign src[`B_CMP] = (r_r.cmp_en & cmp_pos_below) | wdt_exp;
   assign src[`B_MEM] = code_acc & (code_addr > `CODE_LIMIT);

   ////////////////////////////////////////////////////////////////////////////
   // Next state
   always_comb begin
      r_nxt = r_r;
      r_nxt.rsp.pready = 1'b0;
      r_nxt.rsp.pslverr = 1'b0;
      r_nxt.mon_prev = clk_mon;
      if (setup) begin
         r_nxt.rsp.pready = 1'b1;
         unique case (apb_req.paddr)
            `CAUSE_OFS: r_nxt.rsp.prdata = {25'h0, r_r.cause};
            `WDT_CTL_OFS: r_nxt.rsp.prdata = {31'h0, r_r.wdt_en};
            `WDT_LIM_OFS: r_nxt.rsp.prdata = {16'h0, r_r.wdt_lim};
            default: begin
               r_nxt.rsp.prdata = 32'h0;
               r_nxt.rsp.pslverr = 1'b1;
            end
         endcase
      end
      // One-shot retriggered by every edge of the watched clock
      if (!r_r.mcd_en || clk_mon != r_r.mon_prev) begin
         r_nxt.mcd_cnt = 16'h0;
      end else if (r_r.mcd_cnt < 16'(`MCD_CYC)) begin
         r_nxt.mcd_cnt = r_r.mcd_cnt + 16'h1;
      end
      unique case (r_r.ph)
         rst_src_pkg::PH_POR: begin
            if (r_r.cnt == 16'h0) begin
               r_nxt.ph = rst_src_pkg::PH_RUN;
               r_nxt.core_rst = 1'b0;
            end else begin
               r_nxt.cnt = r_r.cnt - 16'h1;
            end
         end
         rst_src_pkg::PH_HOLD: begin
            if (!(r_r.hold_pin ? src[`B_PIN] : src[`B_SUP])) begin
               // Short settle only, never the power-on delay
               r_nxt.ph = rst_src_pkg::PH_PULSE;
               r_nxt.cnt = 16'(`RST_HOLD_CYC - 1);
               r_nxt.pin_oe = 1'b0;
               if (r_r.hold_pin) r_nxt.cause = 7'h1 << `B_PIN;
            end
         end
         rst_src_pkg::PH_PULSE: begin
            if (r_r.cnt == 16'h0) begin
               r_nxt.ph = rst_src_pkg::PH_RUN;
               r_nxt.core_rst = 1'b0;
            end else begin
               r_nxt.cnt = r_r.cnt - 16'h1;
            end
         end
         rst_src_pkg::PH_RUN: begin
            if (r_r.wdt_en) begin
               if (r_r.wdt_pre == 4'(`WDT_DIV - 1)) begin
                  r_nxt.wdt_pre = 4'h0;
                  if (!wdt_exp) r_nxt.wdt_cnt = r_r.wdt_cnt + 16'h1;
               end else begin
                  r_nxt.wdt_pre = r_r.wdt_pre + 4'h1;
               end
            end
            if (wr_cause) begin
               if (apb_req.pwdata[`B_SUP]) r_nxt.vdd_en = 1'b1;
               r_nxt.mcd_en = apb_req.pwdata[`B_MCD];
               r_nxt.cmp_en = apb_req.pwdata[`B_CMP];
            end
            if (wr_ctl) begin
               r_nxt.wdt_en = apb_req.pwdata[`B_WDT_EN];
               if (apb_req.pwdata[`B_WDT_KICK]) r_nxt.wdt_cnt = 16'h0;
            end
            if (wr_lim) r_nxt.wdt_lim = apb_req.pwdata[15:0];
            if (src != 7'h0) begin
               // One merged reset; the first source wins the flag
               r_nxt.core_rst = 1'b1;
               r_nxt.cause = first_src(src);
               r_nxt.wdt_en = 1'b1;
               r_nxt.wdt_pre = 4'h0;
               r_nxt.wdt_cnt = 16'h0;
               r_nxt.mcd_en = 1'b0;
               r_nxt.cmp_en = 1'b0;
               // Supply monitor enable survives, including an enable written now
               if (src[`B_SUP] || src[`B_PIN]) begin
                  r_nxt.ph = rst_src_pkg::PH_HOLD;
                  r_nxt.hold_pin = ~src[`B_SUP];
                  r_nxt.pin_oe = src[`B_SUP];
                  // Pin flag only appears on leaving the reset
                  if (!src[`B_SUP]) r_nxt.cause = 7'h0;
               end else begin
                  r_nxt.ph = rst_src_pkg::PH_PULSE;
                  r_nxt.cnt = 16'(`RST_HOLD_CYC - 1);
               end
            end
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // State register; data memory is never touched here
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         r_r <= '{ph: rst_src_pkg::PH_POR, cnt: 16'(`POR_DLY_CYC),
                  cause: 7'h1 << `B_SUP, wdt_en: 1'b1, wdt_lim: `WDT_LIM_RST,
                  core_rst: 1'b1, default: '0};
      end else begin
         r_r <= r_nxt;
      end
   end

   assign apb_rsp = r_r.rsp;
   assign core_rst = r_r.core_rst;
   assign pin_rst_out = r_r.pin_out;
   assign pin_rst_oe = r_r.pin_oe;

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   sequence pulse_s;
      core_rst [*4] ##1 !core_rst;
   endsequence
   sequence leave_hold_s;
      r_r.ph == rst_src_pkg::PH_HOLD && !r_r.hold_pin && !supply_low;
   endsequence

   supply_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      run && r_r.vdd_en && supply_low |=> core_rst && pin_rst_oe && r_r.cause[`B_SUP])
      else $error("supply reset not held");
   vdd_keep_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      !$fell(r_r.vdd_en)) else $error("supply monitor enable lost");
   vdd_enable_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      wr_cause && apb_req.pwdata[`B_SUP] |=> r_r.vdd_en) else $error("monitor not enabled");
   no_por_delay_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      leave_hold_s |=> !pin_rst_oe ##0 pulse_s) else $error("release too slow");
   pin_flag_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      r_r.ph == rst_src_pkg::PH_HOLD && r_r.hold_pin && pin_rst_in_b
      |=> r_r.cause == 7'h01 && !pin_rst_oe) else $error("pin flag missing");
   clock_loss_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      run && src == 7'h04 |=> r_r.cause == 7'h04 && !pin_rst_oe ##0 pulse_s)
      else $error("clock loss reset wrong");
   cmp_wdt_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      run && src == 7'h20 |=> r_r.cause == 7'h20 && core_rst) else $error("bit 5 reset wrong");
   mem_err_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      run && src == 7'h40 |=> r_r.cause == 7'h40 ##0 pulse_s) else $error("memory error reset");
   soft_rst_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      run && src == 7'h10 |=> r_r.cause == 7'h10 && !pin_rst_oe) else $error("soft reset wrong");
   wdt_on_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      $fell(core_rst) |-> r_r.wdt_en && r_r.wdt_pre == 4'h0) else $error("watchdog off");
   one_flag_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      !core_rst |-> $onehot0(r_r.cause)) else $error("several cause flags");

   ////////////////////////////////////////////////////////////////////////////
   // Bus, cause register and pin checks
   sequence setup_s;
      apb_req.psel && !apb_req.penable;
   endsequence
   sequence answer_s;
      apb_rsp.pready ##1 !apb_rsp.pready;
   endsequence

   bus_answer_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      setup_s |=> answer_s) else $error("bus answer not one cycle");
   reserved_zero_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      r_r.cause[3] == 1'b0) else $error("reserved cause bit set");
   pin_low_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      pin_rst_out == 1'b0) else $error("pin drive value not low");
   internal_pin_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      pin_rst_oe |-> r_r.cause[`B_SUP] && r_r.ph != rst_src_pkg::PH_RUN)
      else $error("pin driven by internal source");
   locked_wr_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      !run |-> !wr) else $error("write taken during reset");
endmodule : rst_src_ctrl

// ---- verilog/rst_src_params.svh ----
/*
 Register map, field positions, reset values and timing counts of the
 reset source controller. Assumes a 10 MHz system clock.
*/
`ifndef RST_SRC_PARAMS_SVH
`define RST_SRC_PARAMS_SVH
`define CLK_MHZ 10
`define CAUSE_OFS 8'h00
`define WDT_CTL_OFS 8'h04
`define WDT_LIM_OFS 8'h08
`define B_PIN 0
`define B_SUP 1
`define B_MCD 2
`define B_SW 4
`define B_CMP 5
`define B_MEM 6
`define B_WDT_EN 0
`define B_WDT_KICK 1
`define POR_DLY_US 100
`define POR_DLY_CYC (`POR_DLY_US * `CLK_MHZ)
`define RST_HOLD_NS 400
`define RST_HOLD_CYC ((`RST_HOLD_NS * `CLK_MHZ + 999) / 1000)
`define MCD_US 100
`define MCD_CYC (`MCD_US * `CLK_MHZ)
`define WDT_DIV 12
`define WDT_LIM_RST 16'hffff
`define CODE_LIMIT 16'h0fff
`endif

// ---- verilog/rst_src_pkg.sv ----
/*
 Types of the reset source controller: sequencer phases, APB carriers
 and the state record. Assumes the params header for widths' meaning.
*/
package rst_src_pkg;
   typedef enum logic [1:0] {PH_POR, PH_HOLD, PH_PULSE, PH_RUN} phase_t;
   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [7:0] paddr;
      logic [31:0] pwdata;
   } apb_req_t;
   typedef struct packed {
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } apb_rsp_t;
   typedef struct packed {
      phase_t ph;
      logic [15:0] cnt;
      logic [6:0] cause;
      logic hold_pin;
      logic vdd_en;
      logic mcd_en;
      logic cmp_en;
      logic wdt_en;
      logic [3:0] wdt_pre;
      logic [15:0] wdt_cnt;
      logic [15:0] wdt_lim;
      logic [15:0] mcd_cnt;
      logic mon_prev;
      logic core_rst;
      logic pin_out;
      logic pin_oe;
      apb_rsp_t rsp;
   } state_t;
endpackage : rst_src_pkg
